/* verilog/sdp_pkg.sv */
// Constants for the synthesizer divider and power control block
package sdp_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam logic [7:0]  OFS_LOOP_CTRL   = 8'h18;
  localparam logic [7:0]  OFS_DIV_SETUP   = 8'h19;
  localparam logic [7:0]  OFS_PWR_CTRL    = 8'h1a;
  localparam logic [15:0] RST_LOOP_CTRL   = 16'h2808;
  localparam logic [15:0] RST_DIV_SETUP   = 16'h0440;
  localparam logic [15:0] RST_PWR_CTRL    = 16'h0020;
  localparam logic [15:0] WMASK_LOOP_CTRL = 16'hfff8;
  localparam int          B_SYN_RESET     = 12;
  localparam int          B_DIVSYNC_ENA   = 11;
  localparam int          B_SYN_ENA       = 10;
  localparam int          F_PUMP_LO       = 6;
  localparam int          F_PRESC_LO      = 3;
  localparam int          F_MDIV_LO       = 8;
  localparam int          F_NDIV_LO       = 4;
  localparam int          F_VBIAS_LO      = 2;
  localparam int          F_VCO_LO        = 10;
  localparam int          B_BIAS_SLEEP    = 7;
  localparam int          B_TSENSE_SLEEP  = 6;
  localparam int          B_SYN_SLEEP     = 5;
  localparam int          B_CLKRX_SLEEP   = 4;
  localparam int          CHANNELS        = 4;
  localparam logic [3:0]  PRESC_ZERO_DIV  = 4'h8;
  typedef enum logic [2:0]
  {
    PUMP_OFF    = 3'b001,
    PUMP_SINGLE = 3'b010,
    PUMP_DUAL   = 3'b100
  } sdp_pump_t;
endpackage

/* verilog/sdp_decode.sv */
// Divider and pump field decoder
`timescale 1ns/1ns
module sdp_decode
  import sdp_pkg::*;
(
  input  wire logic [1:0] pumpCode,   // Pump select code
  input  wire logic [2:0] prescCode,  // Prescaler code
  input  wire logic [7:0] mCode,      // M divider code
  input  wire logic [3:0] nCode,      // N divider code
  output sdp_pump_t       pumpMode,   // Decoded pump
  output logic            pumpOn,     // Any pump active
  output logic [3:0]      prescRatio, // Prescaler ratio
  output logic [7:0]      mValue,     // M divide value
  output logic [4:0]      nValue      // N divide value
);
  always_comb
  begin
    case (pumpCode)
      2'h1:    pumpMode = PUMP_SINGLE;
      2'h3:    pumpMode = PUMP_DUAL;
      default: pumpMode = PUMP_OFF;
    endcase
    pumpOn = (pumpCode == 2'h1) || (pumpCode == 2'h3);
    if (prescCode == 3'h0)
      prescRatio = PRESC_ZERO_DIV;
    else
      prescRatio = {1'b0, prescCode};
    if (mCode[7])
      mValue = {mCode[6:0], 1'b0};
    else
      mValue = {1'b0, mCode[6:0]};
    nValue = {1'b0, nCode} + 5'h01;
  end
endmodule

/* verilog/sdp_top.sv */
// Synthesizer divider and power-down control registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module sdp_top
  import sdp_pkg::*;
(
  input  wire logic              sys_clk,         // 250 MHz clock
  input  wire logic              rst_b,           // Async reset, active low
  input  wire logic [ADDR_W-1:0] regAddr,         // Register address
  input  wire logic [DATA_W-1:0] regWdata,        // Write data
  input  wire logic              regWr,           // Write strobe
  input  wire logic              regRd,           // Read strobe
  output logic      [DATA_W-1:0] regRdata,        // Read data, cycle after strobe
  input  wire logic [2:0]        lfVoltLevel,     // Loop-filter voltage from analog
  input  wire logic              syncIn,          // Parallel-bus sync pin
  output logic                   synthClkSel,     // 1: multiplied clock, 0: bypass
  output logic [2:0]             pumpSelect,      // One-hot pump mode
  output logic                   pumpEnable,      // Charge pump active
  output logic [3:0]             prescDivide,     // Prescaler ratio
  output logic [7:0]             mDivide,         // M divide value
  output logic [4:0]             nDivide,         // N divide value
  output logic [1:0]             vcoBiasTune,     // VCO bias tuning
  output logic [5:0]             vcoCoarseTune,   // VCO coarse tuning
  output logic                   loopFilterDump,  // Hold loop filter discharged
  output logic                   nDivSync,        // N divider sync pulse
  output logic                   biasSleep,       // Bias amplifier sleep
  output logic                   tsenseSleep,     // Temperature sensor sleep
  output logic                   synthSleep,      // Synthesizer sleep
  output logic                   clkRxSleep,      // Clock input receiver sleep
  output logic                   syncStrobeSleep, // Sync strobe receiver sleep
  output logic [CHANNELS-1:0]    chanSleep        // Channel A..D sleep, A in bit 3
);
  logic [DATA_W-1:0] loopCtrl;
  logic [DATA_W-1:0] divSetup;
  logic [DATA_W-1:0] pwrCtrl;
  logic [2:0]        lfMeta;
  logic [2:0]        lfSync;
  logic              syncMeta;
  logic              syncStage;
  logic              syncLast;
  logic              syncRise;
  sdp_pump_t         pumpMode;
  logic              pumpOn;
  logic [3:0]        prescRatio;
  logic [7:0]        mValue;
  logic [4:0]        nValue;
  logic [DATA_W-1:0] next_rdata;

  // Register writes; indicator bits of loop control are not stored
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      loopCtrl <= RST_LOOP_CTRL;
    else if (regWr && regAddr == OFS_LOOP_CTRL)
      loopCtrl <= regWdata & WMASK_LOOP_CTRL;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      divSetup <= RST_DIV_SETUP;
    else if (regWr && regAddr == OFS_DIV_SETUP)
      divSetup <= regWdata;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pwrCtrl <= RST_PWR_CTRL;
    else if (regWr && regAddr == OFS_PWR_CTRL)
      pwrCtrl <= regWdata;
  end

  // Pin synchronisers: two flops before any logic reads a pin
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      lfMeta <= 3'h0;
    else
      lfMeta <= lfVoltLevel;
  end

  // The indicator is a slow level, so bitwise sampling is safe
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      lfSync <= 3'h0;
    else
      lfSync <= lfMeta;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      syncMeta <= 1'b0;
    else
      syncMeta <= syncIn;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      syncStage <= 1'b0;
    else
      syncStage <= syncMeta;
  end

  // Delayed copy for the edge detector; reads only the second flop
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      syncLast <= 1'b0;
    else
      syncLast <= syncStage;
  end

  assign syncRise = syncStage && !syncLast;

  sdp_decode u_decode
  (
    .pumpCode   (loopCtrl[F_PUMP_LO+1:F_PUMP_LO]),
    .prescCode  (loopCtrl[F_PRESC_LO+2:F_PRESC_LO]),
    .mCode      (divSetup[F_MDIV_LO+7:F_MDIV_LO]),
    .nCode      (divSetup[F_NDIV_LO+3:F_NDIV_LO]),
    .pumpMode   (pumpMode),
    .pumpOn     (pumpOn),
    .prescRatio (prescRatio),
    .mValue     (mValue),
    .nValue     (nValue)
  );

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = '0;
    case (regAddr)
      OFS_LOOP_CTRL: next_rdata = {loopCtrl[15:3], lfSync};
      OFS_DIV_SETUP: next_rdata = divSetup;
      OFS_PWR_CTRL:  next_rdata = pwrCtrl;
      default:       next_rdata = '0;
    endcase
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdata <= '0;
    else if (regRd)
      regRdata <= next_rdata;
    else
      regRdata <= '0;
  end

  // Synthesizer controls
  // Multiplied clock when enabled, bypass otherwise
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      synthClkSel <= 1'b0;
    else
      synthClkSel <= loopCtrl[B_SYN_ENA];
  end

  // Unused pump code falls back to no pump
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pumpSelect <= PUMP_OFF;
    else
      pumpSelect <= pumpMode;
  end

  // Any active pump, single or dual
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pumpEnable <= 1'b0;
    else
      pumpEnable <= pumpOn;
  end

  // Code zero stands for the largest ratio
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      prescDivide <= 4'h1;
    else
      prescDivide <= prescRatio;
  end

  // Top code bit doubles the low seven bits
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mDivide <= 8'h04;
    else
      mDivide <= mValue;
  end

  // Divide value is one above the code
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      nDivide <= 5'h05;
    else
      nDivide <= nValue;
  end

  // Bias tuning passes through; software picks the normal setting
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vcoBiasTune <= 2'h0;
    else
      vcoBiasTune <= divSetup[F_VBIAS_LO+1:F_VBIAS_LO];
  end

  // Held while the restart bit stands; software toggles it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      loopFilterDump <= 1'b0;
    else
      loopFilterDump <= loopCtrl[B_SYN_RESET];
  end

  // One pulse per synced rising edge of the sync pin, only while enabled
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      nDivSync <= 1'b0;
    else
      nDivSync <= loopCtrl[B_DIVSYNC_ENA] && syncRise;
  end

  // VCO coarse tuning and power-down controls
  // Coarse tuning code for the oscillator
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      vcoCoarseTune <= 6'h00;
    else
      vcoCoarseTune <= pwrCtrl[F_VCO_LO+5:F_VCO_LO];
  end

  // Bias amplifier sleep
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      biasSleep <= 1'b0;
    else
      biasSleep <= pwrCtrl[B_BIAS_SLEEP];
  end

  // Temperature sensor off
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      tsenseSleep <= 1'b0;
    else
      tsenseSleep <= pwrCtrl[B_TSENSE_SLEEP];
  end

  // Sleeps from reset until software wakes it
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      synthSleep <= 1'b1;
    else
      synthSleep <= pwrCtrl[B_SYN_SLEEP];
  end

  // Clock input receiver sleep
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      clkRxSleep <= 1'b0;
    else
      clkRxSleep <= pwrCtrl[B_CLKRX_SLEEP];
  end

  // The strobe receiver shares the clock receiver's sleep bit
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      syncStrobeSleep <= 1'b0;
    else
      syncStrobeSleep <= pwrCtrl[B_CLKRX_SLEEP];
  end

  // One sleep flop per converter channel, channel A in the top bit
  for (genvar ch = 0; ch < CHANNELS; ch++)
  begin : g_chanSleep
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        chanSleep[ch] <= 1'b0;
      else
        chanSleep[ch] <= pwrCtrl[ch];
    end
  end
endmodule

/* tb/sdp_top_monitor.sv */
// Assertion checker for the synthesizer control registers
`timescale 1ns/1ns
module sdp_top_monitor
  import sdp_pkg::*;
(
  input wire logic        sys_clk,         // Clock
  input wire logic        rst_b,           // Reset
  input wire logic [7:0]  regAddr,         // Address
  input wire logic [15:0] regWdata,        // Write data
  input wire logic        regWr,           // Write strobe
  input wire logic        synthClkSel,     // Clock select
  input wire logic        pumpEnable,      // Pump on
  input wire logic [3:0]  prescDivide,     // Prescaler
  input wire logic [7:0]  mDivide,         // M value
  input wire logic [4:0]  nDivide,         // N value
  input wire logic        synthSleep,      // Synth sleep
  input wire logic        syncStrobeSleep, // Strobe sleep
  input wire logic        nDivSync         // Sync pulse
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_wr(logic [7:0] a);
    regWr && regAddr == a;
  endsequence
  property p_mdiv;
    s_wr(OFS_DIV_SETUP) |-> ##2 mDivide == ($past(regWdata[15], 2) ? {$past(regWdata[14:8], 2), 1'b0}
                                                                   : {1'b0, $past(regWdata[14:8], 2)});
  endproperty
  a_clk_select: assert property (s_wr(OFS_LOOP_CTRL) |-> ##2 synthClkSel == $past(regWdata[10], 2))
    else $error("clock select wrong");
  a_pump_enable: assert property (s_wr(OFS_LOOP_CTRL) |-> ##2 pumpEnable == $past(regWdata[6], 2))
    else $error("pump enable wrong");
  a_presc_zero: assert property (s_wr(OFS_LOOP_CTRL) ##0 regWdata[5:3] == 3'h0 |-> ##2 prescDivide == 4'h8)
    else $error("prescaler zero code wrong");
  a_mdiv_value: assert property (p_mdiv)
    else $error("M value wrong");
  a_ndiv_value: assert property (s_wr(OFS_DIV_SETUP) |-> ##2 nDivide == {1'b0, $past(regWdata[7:4], 2)} + 5'h1)
    else $error("N value wrong");
  a_synth_sleep: assert property (s_wr(OFS_PWR_CTRL) |-> ##2 synthSleep == $past(regWdata[5], 2))
    else $error("synth sleep wrong");
  a_strobe_sleep: assert property (s_wr(OFS_PWR_CTRL) |-> ##2 syncStrobeSleep == $past(regWdata[4], 2))
    else $error("strobe receiver sleep wrong");
  a_sync_single: assert property (nDivSync |=> !nDivSync)
    else $error("sync pulse too long");
endmodule

bind sdp_top sdp_top_monitor u_mon (.*);

/* tb/tb_top.sv */
// Self-checking bench for the synthesizer control registers
`timescale 1ns/1ns
module tb_top
  import sdp_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  regAddr = 8'h0;
  logic [15:0] regWdata = 16'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [2:0]  lfVoltLevel = 3'h5;
  logic        syncIn = 1'b0;
  logic [15:0] regRdata;
  logic [7:0]  mDivide;
  logic [5:0]  vcoCoarseTune;
  logic [4:0]  nDivide;
  logic [3:0]  prescDivide, chanSleep;
  logic [2:0]  pumpSelect;
  logic [1:0]  vcoBiasTune;
  logic        synthClkSel, pumpEnable, loopFilterDump, nDivSync, biasSleep, tsenseSleep;
  logic        synthSleep, clkRxSleep, syncStrobeSleep, rdSeen = 1'b0;
  int          errors = 0;
  int          samples_checked = 0;
  logic [15:0] rdQ[$];

  sdp_top u_dut (.*);

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Strobes stay up after a transfer so back-to-back calls assign once per step
  task automatic idle();
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask

  task automatic do_reset();
    idle();
    rst_b <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Let the indicator synchroniser fill before the first read
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    regRd    <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Expected read data is queued here and popped by the watcher below
  task automatic rd(logic [7:0] a, logic [15:0] e);
    regAddr <= a;
    regRd   <= 1'b1;
    regWr   <= 1'b0;
    rdQ.push_back(e);
    @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    if (rdSeen)
      check("regRdata", regRdata, rdQ.pop_front());
    rdSeen <= regRd;
  end

  task automatic chk_out(logic [15:0] l, logic [15:0] d, logic [15:0] p);
    logic [15:0] eL, eD, eP;
    eL = {6'h0, l[10], l[12], ((l[7:6] == 2'b11) ? 3'h4 : ((l[7:6] == 2'b01) ? 3'h2 : 3'h1)), l[6],
          ((l[5:3] == 3'h0) ? 4'h8 : {1'b0, l[5:3]})};
    eD = {(d[15] ? {d[14:8], 1'b0} : {1'b0, d[14:8]}), {1'b0, d[7:4]} + 5'h1, d[3:2], 1'b0};
    eP = {1'b0, p[15:10], p[7:4], p[4], p[3:0]};
    idle();
    repeat (2) @(posedge sys_clk);
    #1;
    check("loop", {6'h0, synthClkSel, loopFilterDump, pumpSelect, pumpEnable, prescDivide}, eL);
    check("div", {mDivide, nDivide, vcoBiasTune, 1'b0}, eD);
    check("pwr", {1'b0, vcoCoarseTune, biasSleep, tsenseSleep, synthSleep, clkRxSleep,
                  syncStrobeSleep, chanSleep}, eP);
    @(posedge sys_clk);
  endtask

  // Counts sync pulses after one rising edge of the pin
  task automatic sync_try(logic en, logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0;
    wr(OFS_LOOP_CTRL, {4'h0, en, 11'h0});
    idle();
    syncIn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    syncIn <= 1'b1;
    repeat (8)
    begin
      @(posedge sys_clk);
      #1;
      if (nDivSync === 1'b1)
        n++;
    end
    check("nDivSync pulses", n, exp);
    @(posedge sys_clk);
  endtask

  initial
  begin
    #100000;
    errors++;
    print_verdict();
  end

  initial
  begin
    logic [15:0] a, b, c;
    void'($urandom(19));
    do_reset();
    rd(OFS_LOOP_CTRL, RST_LOOP_CTRL | 16'h0005);
    rd(OFS_DIV_SETUP, 16'h0440);
    rd(OFS_PWR_CTRL, 16'h0020);
    wr(8'h1b, 16'hffff);
    rd(8'h1b, 16'h0000);
    chk_out(RST_LOOP_CTRL, 16'h0440, 16'h0020);
    for (int i = 0; i < 16; i++)
    begin
      a = 16'($urandom);
      b = 16'($urandom) | 16'h0400;
      c = 16'($urandom);
      a[7:3] = {i[1:0], i[2:0]};
      b[3:2] = 2'b01;
      wr(OFS_LOOP_CTRL, a);
      rd(OFS_LOOP_CTRL, (a & 16'hfff8) | {13'h0, lfVoltLevel});
      wr(OFS_DIV_SETUP, b);
      rd(OFS_DIV_SETUP, b);
      wr(OFS_PWR_CTRL, c);
      rd(OFS_PWR_CTRL, c);
      lfVoltLevel <= 3'($urandom);
      chk_out(a, b, c);
    end
    // Write one coarse code with the indicator held at 3, then read both registers back
    lfVoltLevel <= 3'h3;
    wr(OFS_PWR_CTRL, 16'h8000);
    rd(OFS_PWR_CTRL, 16'h8000);
    rd(OFS_LOOP_CTRL, (a & 16'hfff8) | 16'h0003);
    sync_try(1'b1, 16'h1);
    sync_try(1'b0, 16'h0);
    do_reset();
    rd(OFS_PWR_CTRL, 16'h0020);
    chk_out(RST_LOOP_CTRL, 16'h0440, 16'h0020);
    print_verdict();
  end
endmodule
